// [hw/flash_checksum_scanner.sv]
// Flash checksum scanner with APB registers and flash fetch engine
//
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module flash_checksum_scanner
#(
	parameter int FLASH_BYTES = 16384
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire flash_scan_pkg::apb_req_t apb_in,
	output flash_scan_pkg::apb_rsp_t apb_out,
	input wire logic dbg_is_debugger,
	input wire logic dbg_mem_access,
	input wire logic dbg_internal_access,
	input wire logic dbg_disconnect,
	input wire logic cpu_sleep,
	input wire logic startup_scan_en,
	input wire logic [1:0] startup_section,
	input wire logic [7:0] boot_section_end_fuse,
	input wire logic [7:0] app_section_end_fuse,
	output flash_scan_pkg::flash_req_t flash_out,
	input wire logic [15:0] flash_rdata,
	output logic cpu_stall,
	output logic cpu_hold,
	output logic nmi_req
);
	import flash_scan_pkg::*;

	scan_regs_t st; // Registered state
	scan_regs_t next_st; // Next state
	logic wr_hit; // Write access phase
	logic running; // Engine may advance this cycle
	logic finish; // Last word folded in
	logic fail_evt; // Pass flag driven low
	logic [15:0] crc_new; // CRC after current word
	logic [15:0] last_word; // Index of final word
	logic addr_ok; // Decoded register address

	// One byte through the shift register, MSB first
	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		logic fb;
		r = c;
		for (int i = 7; i >= 0; i--)
		begin
			fb = r[15] ^ b[i];
			r = {r[14:0], 1'b0};
			if (fb)
				r = r ^ CRC_POLY;
		end
		return r;
	endfunction

	// Fresh check from word zero; delay picks the start path
	function automatic scan_regs_t launch(input scan_regs_t s,
		input logic with_delay);
		scan_regs_t r;
		r = s;
		r.busy = 1'b1;
		r.enable = 1'b1;
		r.addr = 16'h0000;
		r.crc = CRC_SEED;
		r.phase = 2'h0;
		r.delay_cnt = 2'h0;
		r.state = with_delay ? ST_DELAY : ST_SCAN;
		return r;
	endfunction

	// Outputs from state; pslverr and the fetch strobe also decode inputs
	assign apb_out.prdata = {24'h000000, st.prdata};
	assign apb_out.pready = 1'b1;
	assign apb_out.pslverr = apb_in.psel & apb_in.penable & ~addr_ok;
	assign flash_out.addr = st.addr;
	assign flash_out.rd = (st.state == ST_SCAN) && running
		&& (st.phase == 2'h0);
	assign cpu_stall = (st.state == ST_SCAN);
	assign cpu_hold = st.startup_run | st.startup_fail;
	assign nmi_req = st.nmi;

	// Next-state logic
	always_comb
	begin
		next_st = st;
		fail_evt = 1'b0;
		finish = 1'b0;
		addr_ok = (apb_in.paddr == ADDR_CTRL_A)
			|| (apb_in.paddr == ADDR_CTRL_B)
			|| (apb_in.paddr == ADDR_STATUS);
		wr_hit = apb_in.psel && apb_in.penable && apb_in.pwrite
			&& addr_ok;
		// Index of the section's final word; reserved code scans full flash
		case (st.section_sel)
			SEC_BOOT_APP:
				last_word = {1'b0, app_section_end_fuse, 7'h00} - 16'h0001;
			SEC_BOOT:
				last_word = {1'b0, boot_section_end_fuse, 7'h00} - 16'h0001;
			default:
				last_word = 16'(FLASH_BYTES / 2 - 1);
		endcase
		// Low byte sits at the even address and goes first
		crc_new = crc_byte(crc_byte(st.crc, flash_rdata[7:0]),
			flash_rdata[15:8]);
		running = !cpu_sleep && !st.dbg_off && !dbg_mem_access;

		// Start-up strap caught on the first edge after release
		if (!st.strap_done)
		begin
			next_st.strap_done = 1'b1;
			if (startup_scan_en)
			begin
				next_st = launch(next_st, 1'b0);
				next_st.section_sel = startup_section;
				next_st.startup_run = 1'b1;
			end
		end

		// Debugger gating
		if (dbg_mem_access)
			next_st.dbg_off = 1'b1;
		else if (dbg_internal_access || dbg_disconnect)
		begin
			next_st.dbg_off = 1'b0;
			// Interrupted check starts over from word zero
			if (st.dbg_off && st.busy && st.state != ST_IDLE)
				next_st = launch(next_st, 1'b0);
		end

		// Scan engine
		case (st.state)
			ST_IDLE:
			begin
				next_st.phase = 2'h0;
			end
			ST_DELAY:
			begin
				// Sleep freezes the count, so scan waits for wake
				if (running)
				begin
					if (st.delay_cnt == START_DELAY_CYC - 2'h1)
						next_st.state = ST_SCAN;
					else
						next_st.delay_cnt = st.delay_cnt + 2'h1;
				end
			end
			ST_SCAN:
			begin
				// A pause between fetch and use relies on flash holding its word
				if (running)
				begin
					if (st.phase == FETCH_PERIOD_CYC - 2'h1)
					begin
						next_st.phase = 2'h0;
						next_st.crc = crc_new;
						next_st.addr = st.addr + 16'h0001;
						if (st.addr == last_word)
						begin
							finish = 1'b1;
							next_st.state = ST_IDLE;
							next_st.busy = 1'b0;
							// Stored checksum folds the remainder to zero
							next_st.pass = (crc_new == 16'h0000);
							fail_evt = (crc_new != 16'h0000);
							if (st.startup_run)
							begin
								next_st.startup_run = 1'b0;
								next_st.startup_fail = (crc_new != 16'h0000);
							end
						end
					end
					else
						next_st.phase = st.phase + 2'h1;
				end
			end
			default:
			begin
				next_st.state = ST_IDLE;
			end
		endcase

		// Reset strobe lands one clock after the write; placed after the
		// engine so a start delay ending now cannot revive the check
		if (st.rst_pend)
		begin
			next_st.rst_pend = 1'b0;
			next_st.enable = 1'b0;
			next_st.mode = 2'h0;
			next_st.section_sel = 2'h0;
			next_st.busy = 1'b0;
			// Status back to its reset image so no false NMI
			next_st.pass = 1'b1;
			next_st.state = ST_IDLE;
		end

		// Register writes; none at all once the NMI fired
		if (wr_hit && !st.nmi)
		begin
			case (apb_in.paddr)
				ADDR_CTRL_A:
				begin
					// Strobe refused while busy if NMI enabled
					if (apb_in.pwdata[CA_RESET_BIT]
						&& (!st.fie || !st.busy))
						next_st.rst_pend = 1'b1;
					if (apb_in.pwdata[CA_FIE_BIT] && !st.busy)
						next_st.fie = 1'b1;
					// Zero is ignored; one relaunches
					if (apb_in.pwdata[CA_ENABLE_BIT])
						next_st = launch(next_st, 1'b1);
				end
				ADDR_CTRL_B:
				begin
					if (!st.busy)
					begin
						next_st.mode = apb_in.pwdata[CB_MODE_LSB +: 2];
						next_st.section_sel =
							apb_in.pwdata[CB_SRC_LSB +: 2];
					end
				end
				ADDR_STATUS:
				begin
					// Only the debugger may write status
					if (dbg_is_debugger)
					begin
						if (!apb_in.pwdata[ST_BUSY_BIT])
						begin
							next_st.busy = 1'b0;
							next_st.state = ST_IDLE;
						end
						else
							next_st = launch(next_st, 1'b0);
						next_st.pass = apb_in.pwdata[ST_PASS_BIT];
						if (!apb_in.pwdata[ST_PASS_BIT])
							fail_evt = 1'b1;
					end
				end
				default:
				begin
					next_st.rst_pend = next_st.rst_pend;
				end
			endcase
		end

		// Enable survives the strobe; only presetn clears it
		next_st.fie = next_st.fie | st.fie;
		// Pass cleared with enable set latches the NMI
		if (fail_evt && next_st.fie)
			next_st.nmi = 1'b1;

		// Read data captured in the setup phase
		if (apb_in.psel && !apb_in.penable && !apb_in.pwrite)
		begin
			case (apb_in.paddr)
				ADDR_CTRL_A:
					next_st.prdata = {6'h00, st.fie, st.enable};
				ADDR_CTRL_B:
					next_st.prdata = {2'h0, st.mode, 2'h0, st.section_sel};
				ADDR_STATUS:
					// Busy still shows while debugger holds us off
					next_st.prdata = {6'h00, st.pass, st.busy};
				default:
					next_st.prdata = 8'h00;
			endcase
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st <= REGS_RST;
		else
			st <= next_st;
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Undisturbed start delay
	sequence s_delay_quiet;
		(st.state == ST_DELAY && st.delay_cnt == 2'h0 && running
			&& !wr_hit && !st.rst_pend && !dbg_internal_access)
		##1 (running && !wr_hit && !st.rst_pend)[*2];
	endsequence

	AST_START_DELAY: assert property (s_delay_quiet |=>
		st.state == ST_SCAN)
		else $error("scan did not begin three cycles after enable");

	AST_ENABLE_STICKY: assert property ($fell(st.enable) |->
		$past(st.rst_pend))
		else $error("enable dropped without reset strobe");

	AST_STALL: assert property (st.state == ST_SCAN |->
		cpu_stall && st.busy)
		else $error("cpu not stalled during scan");

	AST_FETCH_SPACING: assert property (flash_out.rd |=>
		!flash_out.rd [*2])
		else $error("flash fetched faster than every third cycle");

	AST_FAIL_CLEARS: assert property (finish && crc_new != 16'h0000
		&& !wr_hit && !st.rst_pend |=> !st.pass && !st.busy)
		else $error("failing check left pass flag set");

	AST_NMI_RAISE: assert property (fail_evt && next_st.fie |=>
		nmi_req ##1 nmi_req)
		else $error("nmi not raised on pass flag clear");

	AST_NMI_STICKY: assert property (nmi_req |=> nmi_req)
		else $error("nmi request dropped before reset");

	AST_FIE_IDLE: assert property ($rose(st.fie) |->
		!$past(st.busy))
		else $error("interrupt enable set while busy");

	AST_RESET_STROBE: assert property (st.rst_pend |=>
		!st.enable && !st.busy && st.section_sel == 2'h0)
		else $error("reset strobe did not clear registers");

	AST_NMI_LOCK: assert property ($past(st.nmi) && !$past(st.rst_pend)
		|-> $stable(st.section_sel) && $stable(st.mode))
		else $error("register changed after nmi");

	AST_SLEEP_HALT: assert property (cpu_sleep && st.state == ST_SCAN
		&& !dbg_internal_access && !dbg_disconnect && !wr_hit
		&& !st.rst_pend |=> $stable(st.crc) && $stable(st.addr))
		else $error("scan advanced during sleep");

	// Busy freezes control B against any write
	AST_SCAN_CONTROL_B_LOCK: assert property (wr_hit && st.busy
		&& apb_in.paddr == ADDR_CTRL_B && !st.rst_pend
		|=> $stable(st.mode) && $stable(st.section_sel))
		else $error("control B changed while busy");

	// Interrupt enable only falls with presetn
	AST_FIE_STICKY: assert property (st.fie |=> st.fie)
		else $error("interrupt enable cleared without reset");

	// No fetch while the debugger keeps us off
	AST_DBG_QUIET: assert property (st.dbg_off || dbg_mem_access
		|-> !flash_out.rd)
		else $error("flash fetched while debugger holds scanner off");

	// Status read shows busy as it stood at setup
	AST_BUSY_READ: assert property (apb_in.psel && !apb_in.penable
		&& !apb_in.pwrite && apb_in.paddr == ADDR_STATUS
		|=> apb_out.prdata[ST_BUSY_BIT] == $past(st.busy))
		else $error("status read lost the busy flag");

	// Debugger write of busy zero ends the check
	sequence s_dbg_cancel;
		wr_hit && dbg_is_debugger && !st.nmi
			&& apb_in.paddr == ADDR_STATUS && !apb_in.pwdata[ST_BUSY_BIT];
	endsequence

	AST_DBG_CANCEL: assert property (s_dbg_cancel |=>
		!st.busy && st.state == ST_IDLE)
		else $error("debugger busy clear did not stop the check");

	// Failed start-up check keeps the CPU parked
	AST_STARTUP_FAIL: assert property (finish && st.startup_run
		&& crc_new != 16'h0000 |=> cpu_hold ##1 cpu_hold)
		else $error("cpu released after failed start-up check");

	// Sleep during the start delay keeps the check from starting
	AST_DELAY_SLEEP: assert property (cpu_sleep
		&& st.state == ST_DELAY && !wr_hit && !dbg_internal_access
		&& !dbg_disconnect |=> st.state != ST_SCAN)
		else $error("scan began while asleep");

	// Strobe brings status back to its reset image
	AST_STROBE_STATUS: assert property (st.rst_pend && !wr_hit
		|=> st.pass && !st.busy)
		else $error("reset strobe left status dirty");

endmodule

// [hw/flash_scan_pkg.sv]
// Constants, carriers and state layout for the flash checksum scanner
// Functional notes
// - Check begins three cycles after enable write
// - Enable stays set; rewrite one relaunches; zero ignored
// - Start-up scan: pass runs code, fail holds CPU
// - Every scan owns flash and stalls CPU until done; mode field is stored only
// - One 16-bit flash word every third cycle
// - Failed check clears the pass flag
// - Pass clear with enable raises sticky NMI
// - Fail interrupt enable set only when idle
// - Reset strobe clears registers, fail interrupt enable excepted, one clock later
// - After NMI all register writes are ignored
// - Busy blocks control B and interrupt enable changes
// - Scanner halts during CPU sleep, resumes on wake
// - Sleep in start delay postpones scan start
// - Debugger access disables; internal access restarts scan
// - Busy stays visible while debugger holds scanner off
// - Debugger busy write cancels or launches a check
// - Debugger pass write zero can trigger NMI
// - Debugger control writes follow CPU protection
// - CCITT CRC, all-ones seed, MSB first, byte upward
// - Section select: full, boot plus app, boot
// - Pass flag defaults to one before any scan
package flash_scan_pkg;

	// Register indexes; byte address is four times the index
	localparam logic [11:0] IDX_CTRL_A = 12'h000;
	localparam logic [11:0] IDX_CTRL_B = 12'h001;
	localparam logic [11:0] IDX_STATUS = 12'h002;
	localparam logic [11:0] ADDR_CTRL_A = 12'(IDX_CTRL_A * 4);
	localparam logic [11:0] ADDR_CTRL_B = 12'(IDX_CTRL_B * 4);
	localparam logic [11:0] ADDR_STATUS = 12'(IDX_STATUS * 4);

	// Field positions
	localparam int CA_RESET_BIT = 7;
	localparam int CA_FIE_BIT = 1;
	localparam int CA_ENABLE_BIT = 0;
	localparam int CB_MODE_LSB = 4;
	localparam int CB_SRC_LSB = 0;
	localparam int ST_PASS_BIT = 1;
	localparam int ST_BUSY_BIT = 0;

	// Section select codes
	localparam logic [1:0] SEC_FULL = 2'h0;
	localparam logic [1:0] SEC_BOOT_APP = 2'h1;
	localparam logic [1:0] SEC_BOOT = 2'h2;

	// CRC and timing
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_SEED = 16'hffff;
	localparam logic [1:0] START_DELAY_CYC = 2'h3;
	localparam logic [1:0] FETCH_PERIOD_CYC = 2'h3;

	typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SCAN} scan_state_t;

	// APB request and answer
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	// Flash read port, word addressed
	typedef struct packed {
		logic rd;
		logic [15:0] addr;
	} flash_req_t;

	// Whole state of the scanner
	typedef struct packed {
		scan_state_t state;
		logic enable;
		logic fie;
		logic [1:0] mode;
		logic [1:0] section_sel;
		logic pass;
		logic busy;
		logic nmi;
		logic rst_pend;
		logic dbg_off;
		logic strap_done;
		logic startup_run;
		logic startup_fail;
		logic [1:0] delay_cnt;
		logic [1:0] phase;
		logic [15:0] addr;
		logic [15:0] crc;
		logic [7:0] prdata;
	} scan_regs_t;

	localparam scan_regs_t REGS_RST = '{
		state: ST_IDLE, enable: 1'b0, fie: 1'b0, mode: 2'h0,
		section_sel: 2'h0, pass: 1'b1, busy: 1'b0, nmi: 1'b0,
		rst_pend: 1'b0, dbg_off: 1'b0, strap_done: 1'b0,
		startup_run: 1'b0, startup_fail: 1'b0, delay_cnt: 2'h0,
		phase: 2'h0, addr: 16'h0000, crc: CRC_SEED, prdata: 8'h00};

endpackage

// [test/flash_model.sv]
// Behavioural program flash answering the scanner's word fetches
`timescale 1ns/1ns
module flash_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire flash_scan_pkg::flash_req_t req,
	output logic [15:0] rdata
);
	// Word store, loaded by the bench
	logic [15:0] mem [256];
	// Cycles the last word stays valid
	logic [1:0] hold;

	// Word held three cycles after a fetch, then a changing pattern so
	// that a late sample cannot pass by luck
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata <= 16'h0000;
			hold <= 2'h0;
		end
		else if (req.rd)
		begin
			rdata <= mem[req.addr[7:0]];
			hold <= 2'h2;
		end
		else if (hold != 2'h0)
			hold <= hold - 2'h1;
		else
			rdata <= ~rdata;
	end
endmodule

// [test/tb.sv]
// Self-checking bench for the flash checksum scanner
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	fails++; $display("ERROR %s exp %h got %h", n, e, g); end end
module tb;
	import flash_scan_pkg::*;
	logic pclk = 0, presetn = 0, dbg = 0, dmem = 0, dint = 0, ddis = 0;
	logic slp = 0, sen = 1, errv;
	logic [1:0] ssec = 2'h2;
	apb_req_t req = '0;
	apb_rsp_t rsp;
	flash_req_t fl;
	logic [15:0] frd;
	logic stall, hold, nmi;
	logic [7:0] rdv;
	// Flash image bytes
	logic [7:0] b [512];
	int fails = 0, comparisons = 0, nrd = 0, nst = 0, cyc = 0;

	flash_checksum_scanner #(.FLASH_BYTES(512)) dut_u (.pclk(pclk),
		.presetn(presetn), .apb_in(req), .apb_out(rsp),
		.dbg_is_debugger(dbg), .dbg_mem_access(dmem),
		.dbg_internal_access(dint), .dbg_disconnect(ddis),
		.cpu_sleep(slp), .startup_scan_en(sen), .startup_section(ssec),
		.boot_section_end_fuse(8'h01), .app_section_end_fuse(8'h02),
		.flash_out(fl), .flash_rdata(frd), .cpu_stall(stall),
		.cpu_hold(hold), .nmi_req(nmi));
	flash_model fm_u (.pclk(pclk), .presetn(presetn), .req(fl),
		.rdata(frd));

	// Clock, 100 ns period
	initial
		forever #50 pclk = ~pclk;

	// Fetch and stall counters, plus the hang limit
	always @(posedge pclk)
	begin
		nrd += fl.rd;
		nst += stall;
		cyc++;
		if (cyc == 40000)
		begin
			fails++;
			conclude();
		end
	end

	task automatic conclude;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One APB transfer; held until pready is seen high
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [7:0] d, input logic g);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
		dbg <= g;
		@(posedge pclk);
		req.penable <= 1'b1;
		forever
		begin
			@(posedge pclk);
			rdv = rsp.prdata[7:0];
			errv = rsp.pslverr;
			if (rsp.pready === 1'b1)
				break;
		end
		req <= '0;
		dbg <= 1'b0;
	endtask

	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00, 1'b0);
		`CHK($sformatf("reg %h", a), e, rdv)
	endtask

	// Bounded wait for the stall output to reach a level
	task automatic wt(input logic v);
		int n;
		n = 0;
		while (stall !== v && n < 3000)
		begin
			@(posedge pclk);
			#1 n++;
		end
		`CHK("stall", v, stall)
	endtask

	task automatic rst(input logic s);
		sen <= s;
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	task automatic done(input int t);
		$display("test %0d finished", t);
	endtask

	function automatic logic [15:0] crcb(input logic [15:0] c,
		input logic [7:0] d);
		for (int k = 7; k >= 0; k--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? CRC_POLY : 16'h0000);
		return c;
	endfunction

	// Boot and full checksums stored big end first, then corruption
	task automatic fill(input logic [7:0] bad);
		logic [15:0] c;
		c = CRC_SEED;
		for (int i = 0; i < 254; i++)
			c = crcb(c, b[i]);
		b[254] = c[15:8];
		b[255] = c[7:0];
		c = CRC_SEED;
		for (int i = 0; i < 510; i++)
			c = crcb(c, b[i]);
		b[510] = c[15:8];
		b[511] = c[7:0];
		b[300] ^= bad;
		for (int k = 0; k < 256; k++)
			fm_u.mem[k] = {b[2 * k + 1], b[2 * k]};
	endtask

	// One software launched check of a section
	task automatic run(input logic [1:0] s, input logic p, input int w);
		xfer(1'b1, ADDR_CTRL_B, {6'h0, s}, 1'b0);
		xfer(1'b1, ADDR_CTRL_A, 8'h01, 1'b0);
		nrd = 0;
		nst = 0;
		repeat (2) @(posedge pclk);
		#1 `CHK("early", 1'b0, stall)
		@(posedge pclk);
		#1 `CHK("start", 1'b1, stall)
		wt(1'b0);
		`CHK("fetches", w, nrd)
		`CHK("period", 1'b1, nst >= 3 * w - 2 && nst <= 3 * w + 2)
		rc(ADDR_STATUS, {6'h0, p, 1'b0});
		xfer(1'b0, ADDR_CTRL_A, 8'h00, 1'b0);
		`CHK("enable", 1'b1, rdv[0])
	endtask

	// Main sequence
	initial
	begin
		int n0;
		void'($urandom(59));
		for (int i = 0; i < 512; i++)
			b[i] = 8'($urandom);
		fill(8'h00);
		rst(1'b1);
		@(posedge pclk);
		#1 `CHK("hold", 1'b1, hold)
		wt(1'b0);
		`CHK("hold", 1'b0, hold)
		rc(ADDR_CTRL_A, 8'h01);
		rc(ADDR_CTRL_B, 8'h02);
		rc(ADDR_STATUS, 8'h02);
		done(1);
		rst(1'b0);
		rc(ADDR_STATUS, 8'h02);
		rc(ADDR_CTRL_B, 8'h00);
		xfer(1'b1, ADDR_CTRL_B, 8'hff, 1'b0);
		rc(ADDR_CTRL_B, 8'h33);
		xfer(1'b0, 12'h010, 8'h00, 1'b0);
		`CHK("slverr", 1'b1, errv)
		xfer(1'b1, ADDR_CTRL_A, 8'h00, 1'b0);
		repeat (10) @(posedge pclk);
		#1 `CHK("idle", 1'b0, stall)
		for (int s = 0; s < 4; s++)
			run(2'(s), 1'b1, s == 2 ? 128 : 256);
		fill(8'h01);
		run(SEC_BOOT, 1'b1, 128);
		run(SEC_FULL, 1'b0, 256);
		done(2);
		xfer(1'b1, ADDR_CTRL_B, 8'h01, 1'b0);
		xfer(1'b1, ADDR_CTRL_A, 8'h01, 1'b0);
		wt(1'b1);
		xfer(1'b1, ADDR_CTRL_B, 8'h02, 1'b0);
		xfer(1'b1, ADDR_CTRL_A, 8'h02, 1'b0);
		rc(ADDR_CTRL_B, 8'h01);
		rc(ADDR_CTRL_A, 8'h01);
		xfer(1'b1, ADDR_CTRL_A, 8'h80, 1'b0);
		repeat (2) @(posedge pclk);
		#1 `CHK("cancel", 1'b0, stall)
		rc(ADDR_CTRL_A, 8'h00);
		rc(ADDR_CTRL_B, 8'h00);
		rc(ADDR_STATUS, 8'h02);
		done(3);
		xfer(1'b1, ADDR_CTRL_A, 8'h01, 1'b0);
		slp <= 1'b1;
		repeat (10) @(posedge pclk);
		#1 `CHK("asleep", 1'b0, stall)
		@(posedge pclk);
		slp <= 1'b0;
		wt(1'b1);
		repeat (5) @(posedge pclk);
		slp <= 1'b1;
		@(posedge pclk);
		n0 = nrd;
		repeat (20) @(posedge pclk);
		#1 `CHK("frozen", n0, nrd)
		`CHK("stalled", 1'b1, stall)
		@(posedge pclk);
		slp <= 1'b0;
		wt(1'b0);
		done(4);
		xfer(1'b1, ADDR_CTRL_A, 8'h01, 1'b0);
		wt(1'b1);
		@(posedge pclk);
		dmem <= 1'b1;
		@(posedge pclk);
		dmem <= 1'b0;
		@(posedge pclk);
		n0 = nrd;
		repeat (10) @(posedge pclk);
		#1 `CHK("dbg off", n0, nrd)
		xfer(1'b0, ADDR_STATUS, 8'h00, 1'b0);
		`CHK("busy", 1'b1, rdv[0])
		dint <= 1'b1;
		@(posedge pclk);
		dint <= 1'b0;
		nrd = 0;
		wt(1'b0);
		`CHK("restart", 256, nrd)
		xfer(1'b1, ADDR_CTRL_A, 8'h01, 1'b0);
		wt(1'b1);
		@(posedge pclk);
		dmem <= 1'b1;
		@(posedge pclk);
		dmem <= 1'b0;
		xfer(1'b1, ADDR_STATUS, 8'h00, 1'b1);
		ddis <= 1'b1;
		@(posedge pclk);
		ddis <= 1'b0;
		repeat (10) @(posedge pclk);
		#1 `CHK("no restart", 1'b0, stall)
		xfer(1'b1, ADDR_STATUS, 8'h01, 1'b1);
		wt(1'b1);
		wt(1'b0);
		xfer(1'b1, ADDR_STATUS, 8'h02, 1'b1);
		rc(ADDR_STATUS, 8'h02);
		done(5);
		xfer(1'b1, ADDR_CTRL_A, 8'h02, 1'b0);
		xfer(1'b1, ADDR_CTRL_A, 8'h80, 1'b0);
		rc(ADDR_CTRL_A, 8'h02);
		`CHK("nmi", 1'b0, nmi)
		xfer(1'b1, ADDR_STATUS, 8'h00, 1'b1);
		repeat (2) @(posedge pclk);
		#1 `CHK("nmi", 1'b1, nmi)
		xfer(1'b1, ADDR_CTRL_B, 8'h01, 1'b0);
		rc(ADDR_CTRL_B, 8'h00);
		rst(1'b0);
		@(posedge pclk);
		#1 `CHK("nmi", 1'b0, nmi)
		xfer(1'b1, ADDR_CTRL_A, 8'h02, 1'b0);
		run(SEC_FULL, 1'b0, 256);
		`CHK("nmi", 1'b1, nmi)
		done(6);
		// Start-up check of the corrupted full flash must park the CPU
		ssec <= SEC_FULL;
		rst(1'b1);
		wt(1'b1);
		wt(1'b0);
		`CHK("hold", 1'b1, hold)
		rc(ADDR_STATUS, 8'h00);
		rc(ADDR_CTRL_A, 8'h01);
		rc(ADDR_CTRL_B, 8'h00);
		done(7);
		conclude();
	end
endmodule
